//--- common/dasr_cfg.svh
/*
 * Offsets, field positions, reset values and fixed values of the
 * accumulator back-end datapath.
 * Assumes byte addresses on a 32-bit Avalon-MM register port.
 */
`ifndef DASR_CFG_SVH
`define DASR_CFG_SVH
// Register byte offsets
`define DASR_OFS_CONFIG   5'h00
`define DASR_OFS_STATUS   5'h04
`define DASR_OFS_ACC1_LO  5'h08
`define DASR_OFS_ACC1_HI  5'h0c
`define DASR_OFS_ACC2_LO  5'h10
`define DASR_OFS_ACC2_HI  5'h14
// Configuration bit positions
`define DASR_CFG_SAT1     0
`define DASR_CFG_SAT2     1
`define DASR_CFG_WIDTH    2
`define DASR_CFG_RND      3
`define DASR_CFG_DATA_WRITE_SATURATION_ENABLE    4
`define DASR_CFG_OVTE1    5
`define DASR_CFG_OVTE2    6
`define DASR_CFG_CATASTROPHIC_TRAP_ENABLE    7
`define DASR_CFG_RESET    8'h00
// Status bit positions
`define DASR_ST_OV1       0
`define DASR_ST_OV2       1
`define DASR_ST_SAT1      2
`define DASR_ST_SAT2      3
`define DASR_ST_ANYOV     4
`define DASR_ST_ANYSAT    5
// Saturation values, rounding half and write-back pointer step
`define DASR_MAX40        40'h7f_ffff_ffff
`define DASR_MIN40        40'h80_0000_0000
`define DASR_MAX32        40'h00_7fff_ffff
`define DASR_MIN32        40'hff_8000_0000
`define DASR_MAX16        16'h7fff
`define DASR_MIN16        16'h8000
`define DASR_HALF16       16'h8000
`define DASR_PTR_STEP     16'h0002
`endif

//--- common/dasr_pkg.sv
/*
 * Types of the accumulator back-end datapath.
 * Assumes the core decoder drives these structs on the core clock.
 */
package dasr_pkg;
  typedef enum logic [2:0] {
    OP_SAC = 3'b000, OP_STORE_ACCUMULATOR_ROUNDED_OP = 3'b001, OP_MAC = 3'b010, OP_MSC = 3'b011,
    OP_MPY = 3'b100, OP_NEGATED_MULTIPLY_OP = 3'b101, OP_ED = 3'b110, OP_EUCLID_DISTANCE_ACCUMULATE_OP = 3'b111
  } dasr_op_t;
  typedef enum logic [1:0] {SRC_ACC1 = 2'b00, SRC_ACC2 = 2'b01, SRC_XBUS = 2'b10} dasr_shsrc_t;
  typedef struct packed {
    logic        valid;
    logic        target;   // 0 accumulator one, 1 accumulator two
    logic        sub;
    logic        zero;     // Zero into the accumulator side
    logic [39:0] operand;
  } dasr_add_req_t;
  typedef struct packed {
    logic        valid;
    dasr_op_t    op;
    logic        target;
    logic        indirect; // Write-back through the pointer
    logic [15:0] addr;     // Store-accumulator address
    logic [15:0] ptr;      // Current write-back pointer
  } dasr_st_req_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
  } dasr_wr_t;
  typedef struct packed {
    logic        valid;
    dasr_shsrc_t src;
    logic        arith;
    logic [5:0]  amount;   // Signed, -16..16
    logic [15:0] xdata;
  } dasr_sh_req_t;
endpackage : dasr_pkg

//--- rtl/dasr_top.sv
/*
 * Accumulator back end: adder pass with overflow and saturation, sticky
 * flags, traps, store rounding, data write saturation, write-back and shifter.
 * Assumes requests from the decoder on CLOCK_I; one adder pass per cycle.
 */
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "dasr_cfg.svh"
module dasr_top
  import dasr_pkg::*;
(
  input  wire logic          CLOCK_I,
  input  wire logic          SRST_I,
  input  wire logic [4:0]    AVS_ADDRESS_I,
  input  wire logic          AVS_READ_I,
  input  wire logic          AVS_WRITE_I,
  input  wire logic [31:0]   AVS_WRITEDATA_I,
  input  wire logic [3:0]    AVS_BYTEENABLE_I,
  output logic [31:0]        AVS_READDATA_O,
  output logic               AVS_WAITREQUEST_O,
  input  wire dasr_add_req_t ADD_I,
  input  wire dasr_st_req_t  STORE_I,
  input  wire dasr_sh_req_t  SHIFT_I,
  output dasr_wr_t           XWRITE_O,
  output logic               PTR_WE_O,
  output logic [15:0]        PTR_DATA_O,
  output logic [39:0]        SHIFT_RESULT_O,
  output logic [15:0]        SHIFT_WORD_O,
  output logic               SHIFT_DONE_O,
  output logic               TRAP_O,
  output logic [5:0]         STATUS_O
);
  logic [7:0]  cfg_q;
  logic [39:0] acc_q [2];
  logic [1:0]  ovf_q, sat_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        wr_go, rd_go;
  logic [31:0] wmerge;
  logic [1:0]  sat_en;
  logic        width40, rnd_conv, data_write_saturation_enable;

  // Configuration fields
  assign sat_en   = cfg_q[`DASR_CFG_SAT2:`DASR_CFG_SAT1];
  assign width40  = cfg_q[`DASR_CFG_WIDTH];
  assign rnd_conv = cfg_q[`DASR_CFG_RND];
  assign data_write_saturation_enable    = cfg_q[`DASR_CFG_DATA_WRITE_SATURATION_ENABLE];

  // One wait cycle per access; a write is acted on when waitrequest drops, a read is sampled in the wait cycle
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  assign wr_go = AVS_WRITE_I & ack_q;
  assign rd_go = AVS_READ_I & ~ack_q;
  assign AVS_READDATA_O = rdata_q;

  // Byte-enable merge against the current register value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      unique case (AVS_ADDRESS_I)
        `DASR_OFS_CONFIG:  rdata_q <= {24'h00_0000, cfg_q};
        `DASR_OFS_STATUS:  rdata_q <= {26'h000_0000, STATUS_O};
        `DASR_OFS_ACC1_LO: rdata_q <= acc_q[0][31:0];
        `DASR_OFS_ACC1_HI: rdata_q <= {24'h00_0000, acc_q[0][39:32]};
        `DASR_OFS_ACC2_LO: rdata_q <= acc_q[1][31:0];
        `DASR_OFS_ACC2_HI: rdata_q <= {24'h00_0000, acc_q[1][39:32]};
        default:           rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      cfg_q <= `DASR_CFG_RESET;
    end else if (wr_go && AVS_ADDRESS_I == `DASR_OFS_CONFIG && AVS_BYTEENABLE_I[0]) begin
      cfg_q <= AVS_WRITEDATA_I[7:0];
    end
  end

  // Adder pass: exact 41-bit sum, then overflow detection
  logic [39:0] a_in, b_in, wrap, sat_val, acc_next;
  logic [40:0] exact;
  logic        ovf39, ovf31, guard_ovf, tgt, do_sat, mode40, flag_set;
  assign tgt  = ADD_I.target;
  assign a_in = ADD_I.zero ? 40'h00_0000_0000 : acc_q[tgt];
  assign b_in = ADD_I.sub ? ~ADD_I.operand : ADD_I.operand;
  assign exact = {a_in[39], a_in} + {b_in[39], b_in} + {40'h00_0000_0000, ADD_I.sub};
  assign wrap  = exact[39:0];
  assign ovf39 = exact[40] ^ exact[39];
  assign ovf31 = ~((&exact[40:31]) | ~(|exact[40:31]));
  assign guard_ovf = ~((&wrap[39:32]) | ~(|wrap[39:32]));
  assign mode40 = width40;

  always_comb begin
    do_sat   = 1'b0;
    flag_set = 1'b0;
    sat_val  = wrap;
    if (sat_en[tgt] && mode40) begin
      do_sat   = ovf39;
      flag_set = ovf39;
      sat_val  = exact[40] ? `DASR_MIN40 : `DASR_MAX40;
    end else if (sat_en[tgt]) begin
      do_sat   = ovf31;
      flag_set = ovf31;
      sat_val  = exact[40] ? `DASR_MIN32 : `DASR_MAX32;
    end else begin
      flag_set = ovf39;
    end
    acc_next = do_sat ? sat_val : wrap;
  end

  // Accumulators: adder pass wins over a software write in the same cycle
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      acc_q[0] <= 40'h00_0000_0000;
      acc_q[1] <= 40'h00_0000_0000;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ADD_I.valid && tgt == i[0]) begin
          acc_q[i] <= acc_next;
        end else if (wr_go && AVS_ADDRESS_I == (i[0] ? `DASR_OFS_ACC2_LO : `DASR_OFS_ACC1_LO)) begin
          acc_q[i][31:0] <= merge(acc_q[i][31:0], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        end else if (wr_go && AVS_ADDRESS_I == (i[0] ? `DASR_OFS_ACC2_HI : `DASR_OFS_ACC1_HI)
                     && AVS_BYTEENABLE_I[0]) begin
          acc_q[i][39:32] <= AVS_WRITEDATA_I[7:0];
        end
      end
    end
  end

  // sticky saturation flags, set beats a write-one clear; guard flags follow each pass
  logic [1:0] sat_clr;
  assign sat_clr = (wr_go && AVS_ADDRESS_I == `DASR_OFS_STATUS && AVS_BYTEENABLE_I[0])
                   ? AVS_WRITEDATA_I[`DASR_ST_SAT2:`DASR_ST_SAT1] : 2'b00;
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      sat_q <= 2'b00;
      ovf_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ADD_I.valid && tgt == i[0] && flag_set) begin
          sat_q[i] <= 1'b1;
        end else if (sat_clr[i]) begin
          sat_q[i] <= 1'b0;
        end
        // guard flag held clear in 32-bit saturation
        if (ADD_I.valid && tgt == i[0]) begin
          ovf_q[i] <= guard_ovf & ~(sat_en[i] & ~mode40);
        end
      end
    end
  end

  assign STATUS_O = {|sat_q, |ovf_q, sat_q, ovf_q};

  // arithmetic warning trap, one pulse per offending pass
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      TRAP_O <= 1'b0;
    end else begin
      TRAP_O <= ADD_I.valid &&
                ((flag_set && !sat_en[tgt] && cfg_q[`DASR_CFG_CATASTROPHIC_TRAP_ENABLE]) ||
                 (guard_ovf && !(sat_en[tgt] && !mode40) &&
                  cfg_q[tgt ? `DASR_CFG_OVTE2 : `DASR_CFG_OVTE1]));
    end
  end

  // Store path: pick source, round, saturate
  logic        st_mac, st_go, st_round, st_src, st_inc, tie;
  logic [39:0] st_acc;
  logic [23:0] st_ext;
  logic [15:0] st_data;
  assign st_mac = STORE_I.op == OP_MAC || STORE_I.op == OP_MSC;
  assign st_go  = STORE_I.valid && (st_mac || STORE_I.op == OP_SAC || STORE_I.op == OP_STORE_ACCUMULATOR_ROUNDED_OP);
  assign st_src = st_mac ? ~STORE_I.target : STORE_I.target;
  assign st_acc = acc_q[st_src];
  assign st_round = STORE_I.op != OP_SAC;
  assign tie = st_acc[15:0] == `DASR_HALF16;
  always_comb begin
    st_inc = 1'b0;
    if (st_round) begin
      st_inc = (rnd_conv && tie) ? st_acc[16] : st_acc[15];
    end
    st_ext = st_acc[39:16] + {23'h00_0000, st_inc};
    st_data = st_ext[15:0];
    // write saturation, sign from bit 39
    if (data_write_saturation_enable && !st_acc[39] && st_ext[23:15] != 9'h000) begin
      st_data = `DASR_MAX16;
    end else if (data_write_saturation_enable && st_acc[39] && st_ext[23:15] != 9'h1ff) begin
      st_data = `DASR_MIN16;
    end
  end

  // write-back; only outputs change, never the accumulator
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      XWRITE_O   <= '0;
      PTR_WE_O   <= 1'b0;
      PTR_DATA_O <= 16'h0000;
    end else begin
      XWRITE_O.valid <= st_go && !(st_mac && !STORE_I.indirect);
      XWRITE_O.addr  <= st_mac ? STORE_I.ptr : STORE_I.addr;
      XWRITE_O.data  <= st_data;
      PTR_WE_O       <= st_go && st_mac;
      PTR_DATA_O     <= STORE_I.indirect ? STORE_I.ptr + `DASR_PTR_STEP : st_data;
    end
  end

  // Barrel shifter operand placement
  logic [39:0] sh_op, sh_res;
  logic [5:0]  sh_neg;
  logic        sh_left;
  logic [4:0]  sh_mag;
  assign sh_left = SHIFT_I.amount[5];
  assign sh_neg  = 6'h00 - SHIFT_I.amount;
  assign sh_mag  = sh_left ? sh_neg[4:0] : SHIFT_I.amount[4:0];
  always_comb begin
    unique case (SHIFT_I.src)
      SRC_ACC1: sh_op = acc_q[0];
      SRC_ACC2: sh_op = acc_q[1];
      default:  sh_op = sh_left ? {24'h00_0000, SHIFT_I.xdata}
                                : {{8{SHIFT_I.arith & SHIFT_I.xdata[15]}}, SHIFT_I.xdata, 16'h0000};
    endcase
    if (sh_left) begin
      sh_res = sh_op << sh_mag;
    end else if (SHIFT_I.arith) begin
      sh_res = $unsigned($signed(sh_op) >>> sh_mag);
    end else begin
      sh_res = sh_op >> sh_mag;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      SHIFT_RESULT_O <= 40'h00_0000_0000;
      SHIFT_WORD_O   <= 16'h0000;
      SHIFT_DONE_O   <= 1'b0;
    end else begin
      SHIFT_DONE_O <= SHIFT_I.valid;
      if (SHIFT_I.valid) begin
        SHIFT_RESULT_O <= sh_res;
        SHIFT_WORD_O   <= sh_left ? sh_res[15:0] : sh_res[31:16];
      end
    end
  end

  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  property p_sticky;
    sat_q[0] && !(sat_clr[0]) |=> sat_q[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag one dropped without clear");
  property p_sup40;
    ADD_I.valid && !tgt && sat_en[0] && width40 && ovf39 && !exact[40]
      |=> acc_q[0] == `DASR_MAX40 && sat_q[0] && STATUS_O[`DASR_ST_ANYSAT];
  endproperty
  a_sup40: assert property (p_sup40) else $error("40-bit saturation wrong");
  property p_sat32;
    ADD_I.valid && tgt && sat_en[1] && !width40 && ovf31 && exact[40]
      |=> acc_q[1] == `DASR_MIN32 && sat_q[1] && !ovf_q[1];
  endproperty
  a_sat32: assert property (p_sat32) else $error("32-bit saturation wrong");
  property p_cat;
    ADD_I.valid && !tgt && !sat_en[0] && ovf39 |=> sat_q[0] && acc_q[0] == $past(wrap);
  endproperty
  a_cat: assert property (p_cat) else $error("catastrophic wrap wrong");
  property p_trap;
    ADD_I.valid && !sat_en[tgt] && ovf39 && cfg_q[`DASR_CFG_CATASTROPHIC_TRAP_ENABLE] |=> TRAP_O;
  endproperty
  a_trap: assert property (p_trap) else $error("catastrophic trap missing");
  property p_noguard;
    ADD_I.valid && !tgt && sat_en[0] && !width40 |=> !ovf_q[0];
  endproperty
  a_noguard: assert property (p_noguard) else $error("guard flag in 32-bit mode");
  property p_conv;
    st_go && STORE_I.op == OP_STORE_ACCUMULATOR_ROUNDED_OP && !rnd_conv && !data_write_saturation_enable && st_acc[15]
      |=> XWRITE_O.data == $past(st_acc[31:16]) + 16'h0001;
  endproperty
  a_conv: assert property (p_conv) else $error("conventional rounding wrong");
  property p_clamp;
    st_go && data_write_saturation_enable && !st_acc[39] && st_acc[38:31] != 8'h00 |=> XWRITE_O.data == `DASR_MAX16;
  endproperty
  a_clamp: assert property (p_clamp) else $error("write clamp wrong");
  property p_ptr;
    st_go && st_mac && STORE_I.indirect |=> PTR_WE_O && PTR_DATA_O == $past(STORE_I.ptr) + 16'h0002;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer step wrong");
  property p_shzero;
    SHIFT_I.valid && SHIFT_I.amount == 6'h00 && SHIFT_I.src == SRC_ACC1
      |=> SHIFT_RESULT_O == $past(acc_q[0]);
  endproperty
  a_shzero: assert property (p_shzero) else $error("zero shift altered operand");
  c_sup40: cover property (ADD_I.valid && sat_en[tgt] && width40 && ovf39);
  c_tie: cover property (st_go && rnd_conv && tie && st_round);
  c_wb: cover property (st_go && st_mac && STORE_I.indirect);
  c_shl: cover property (SHIFT_I.valid && sh_left && sh_mag == 5'h10);
endmodule : dasr_top
`default_nettype wire

//--- testbench/dasr_xbus_model.sv
/*
 * Far-side model: the write-back pointer register beside the X write bus.
 * Assumes the block pulses its pointer write on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dasr_xbus_model
  import dasr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ptr_we_i,
  input  wire logic [15:0] ptr_data_i,
  output logic [15:0]      ptr_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_o <= 16'h0100; // Start address is arbitrary
    end else if (ptr_we_i) begin
      ptr_o <= ptr_data_i;
    end
  end
endmodule : dasr_xbus_model
`default_nettype wire

//--- testbench/dsp_accum_saturate_round_shift_tb_top.sv
/*
 * Self-checking bench of the accumulator back end: saturation modes, flags,
 * traps, store rounding, write-back and shifter.
 * Assumes dasr_top, dasr_pkg and the pointer model; one 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dasr_cfg.svh"
module dsp_accum_saturate_round_shift_tb_top
  import dasr_pkg::*;
();
  logic          clk;
  logic          srst;
  logic [4:0]    avs_addr;
  logic          avs_rd;
  logic          avs_wr;
  logic [31:0]   avs_wdata;
  logic [31:0]   avs_rdata;
  logic          avs_wait;
  dasr_add_req_t add_req;
  dasr_st_req_t  st_req;
  dasr_sh_req_t  sh_req;
  dasr_wr_t      xwr;
  logic          ptr_we;
  logic [15:0]   ptr_data;
  logic [15:0]   w13;
  logic [39:0]   sh_res;
  logic [15:0]   sh_word;
  logic          sh_done;
  logic          trap;
  logic [5:0]    status;
  logic [39:0]   acc_m [2];
  logic [31:0]   rd;
  int            n_mismatch;
  int            check_count;

  dasr_top u_dasr_top (.CLOCK_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(avs_addr), .AVS_READ_I(avs_rd),
    .AVS_WRITE_I(avs_wr), .AVS_WRITEDATA_I(avs_wdata), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(avs_rdata),
    .AVS_WAITREQUEST_O(avs_wait), .ADD_I(add_req), .STORE_I(st_req), .SHIFT_I(sh_req), .XWRITE_O(xwr),
    .PTR_WE_O(ptr_we), .PTR_DATA_O(ptr_data), .SHIFT_RESULT_O(sh_res), .SHIFT_WORD_O(sh_word),
    .SHIFT_DONE_O(sh_done), .TRAP_O(trap), .STATUS_O(status));

  dasr_xbus_model u_dasr_xbus_model (.clk_i(clk), .rst_i(srst), .ptr_we_i(ptr_we), .ptr_data_i(ptr_data),
    .ptr_o(w13));

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_wr    <= wr;
    avs_rd    <= ~wr;
    avs_addr  <= a;
    avs_wdata <= d;
    @(posedge clk iff avs_wait === 1'b0);
    rd = avs_rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
  endtask : bus

  task automatic wacc(input logic i, input logic [39:0] v);
    bus(1'b1, i ? `DASR_OFS_ACC2_LO : `DASR_OFS_ACC1_LO, v[31:0]);
    bus(1'b1, i ? `DASR_OFS_ACC2_HI : `DASR_OFS_ACC1_HI, {24'h0, v[39:32]});
    acc_m[i] = v;
  endtask : wacc

  task automatic racc(input logic i, output logic [39:0] v);
    bus(1'b0, i ? `DASR_OFS_ACC2_LO : `DASR_OFS_ACC1_LO, 32'h0);
    v[31:0] = rd;
    bus(1'b0, i ? `DASR_OFS_ACC2_HI : `DASR_OFS_ACC1_HI, 32'h0);
    v[39:32] = rd[7:0];
  endtask : racc

  // Edge takes the request, valid drops, outputs are read mid-cycle
  task automatic step();
    @(posedge clk);
    add_req.valid <= 1'b0;
    st_req.valid  <= 1'b0;
    sh_req.valid  <= 1'b0;
    @(negedge clk);
  endtask : step

  task automatic add(input logic t, input logic s, input logic z, input logic [39:0] op);
    @(posedge clk);
    add_req <= '{1'b1, t, s, z, op};
    step();
  endtask : add

  task automatic st(input dasr_op_t op, input logic t, input logic ind, input logic [15:0] a);
    @(posedge clk);
    st_req <= '{1'b1, op, t, ind, a, w13};
    step();
  endtask : st

  // Rounded or truncated word, then optional clamp signed by bit 39
  function automatic logic [15:0] exp_store(input logic [39:0] a, input logic rnd, input logic cv, input logic sdw);
    logic        inc;
    logic [24:0] v;
    inc = rnd & a[15] & (~cv | (a[15:0] != 16'h8000) | a[16]);
    v   = {a[39], a[39:16]} + {24'h0, inc};
    if (sdw && !a[39] && v[23:15] != 9'h0) return 16'h7fff;
    if (sdw && a[39] && v[23:15] != 9'h1ff) return 16'h8000;
    return v[15:0];
  endfunction : exp_store

  function automatic logic [39:0] exp_shift(input logic [39:0] o, input logic ar, input logic signed [5:0] n);
    if (n > 0) return ar ? 40'($signed(o) >>> n) : o >> n;
    return o << (-n);
  endfunction : exp_shift

  // Hang guard, far above the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    $display("[FAIL] run length expected finish seen timeout");
    end_sim();
  end

  // Main sequence
  initial begin
    logic [39:0]       v;
    logic [39:0]       e;
    logic [39:0]       o;
    logic [1:0]        sel;
    logic signed [5:0] amt;
    logic [15:0]       x;
    logic              ar;
    logic [39:0]       corner [8];
    corner = '{40'h00_7fff_ffff, 40'hff_8000_7fff, 40'h00_1234_8000, 40'h00_1235_8000,
               40'h80_0000_0000, 40'h7f_ffff_ffff, 40'h00_7fff_8000, 40'h00_1234_c000};
    void'($urandom(32'h6957cf41));
    srst = 1'b1; avs_addr = 5'h0; avs_rd = 1'b0; avs_wr = 1'b0; avs_wdata = 32'h0;
    add_req = '0; st_req = '0; sh_req = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, `DASR_OFS_CONFIG, 32'h0); chk("config reset", 40'h0, rd);
    bus(1'b0, `DASR_OFS_STATUS, 32'h0); chk("status reset", 40'h0, rd);
    bus(1'b1, 5'h18, 32'hffff_ffff);
    bus(1'b0, 5'h18, 32'h0); chk("unmapped", 40'h0, rd);
    $display("test reset finished");
    bus(1'b1, `DASR_OFS_CONFIG, 32'h07);
    wacc(1'b0, `DASR_MAX40);
    wacc(1'b1, `DASR_MIN40);
    add(1'b0, 1'b0, 1'b0, 40'h1); chk("trap sat on", 40'h0, trap);
    add(1'b1, 1'b1, 1'b0, 40'h1);
    racc(1'b0, v); chk("acc1 max40", `DASR_MAX40, v);
    racc(1'b1, v); chk("acc2 min40", `DASR_MIN40, v);
    chk("status 40", 40'h3f, status);
    bus(1'b1, `DASR_OFS_STATUS, 32'h0c);
    @(negedge clk); chk("status clear", 40'h13, status);
    $display("test forty-bit finished");
    // Both accumulators saturate at 1.31; guard flag of accumulator one is still set from before
    bus(1'b1, `DASR_OFS_CONFIG, 32'h03);
    add(1'b1, 1'b0, 1'b1, 40'h0); chk("guard drop", 40'h11, status);
    wacc(1'b0, `DASR_MAX32);
    add(1'b0, 1'b0, 1'b0, 40'h1); chk("status 32", 40'h24, status);
    racc(1'b0, v); chk("acc1 max32", `DASR_MAX32, v);
    wacc(1'b0, `DASR_MIN32);
    add(1'b0, 1'b1, 1'b0, 40'h1);
    racc(1'b0, v); chk("acc1 min32", `DASR_MIN32, v);
    wacc(1'b1, `DASR_MIN32);
    add(1'b1, 1'b1, 1'b0, 40'h1);
    racc(1'b1, v); chk("acc2 min32", `DASR_MIN32, v);
    add(1'b0, 1'b0, 1'b1, 40'h5); chk("sticky", 40'h2c, status);
    $display("test thirty-two-bit finished");
    bus(1'b1, `DASR_OFS_CONFIG, 32'h80);
    bus(1'b1, `DASR_OFS_STATUS, 32'h0c);
    wacc(1'b1, `DASR_MAX40);
    add(1'b1, 1'b0, 1'b0, 40'h1); chk("trap wrap", 40'h1, trap);
    chk("status wrap", 40'h3a, status);
    racc(1'b1, v); chk("acc2 wrap", `DASR_MIN40, v);
    // Negative wrap on accumulator one loses its sign the other way
    wacc(1'b0, `DASR_MIN40);
    add(1'b0, 1'b1, 1'b0, 40'h1); chk("trap wrap one", 40'h1, trap);
    racc(1'b0, v); chk("acc1 wrap", `DASR_MAX40, v);
    bus(1'b1, `DASR_OFS_CONFIG, 32'h20);
    add(1'b0, 1'b0, 1'b1, 40'h01_0000_0000); chk("trap guard", 40'h1, trap);
    chk("status guard", 40'h3f, status);
    $display("test overflow finished");
    for (int i = 0; i < 24; i++) begin
      v   = (i < 8) ? corner[i] : 40'({$urandom, $urandom});
      sel = (i < 7) ? 2'b11 : (i == 7) ? 2'b00 : 2'($urandom);
      bus(1'b1, `DASR_OFS_CONFIG, {27'h0, sel, 3'h0});
      wacc(i[0], v);
      st(i[1] ? OP_STORE_ACCUMULATOR_ROUNDED_OP : OP_SAC, i[0], 1'b0, 16'(i * 2));
      e = 40'(exp_store(v, i[1], sel[0], sel[1]));
      chk("store data", e, 40'(xwr.data));
      chk("store addr", 40'({1'b1, 16'(i * 2)}), 40'({xwr.valid, xwr.addr}));
      racc(i[0], o); chk("acc kept", v, o);
    end
    $display("test store finished");
    bus(1'b1, `DASR_OFS_CONFIG, 32'h0);
    wacc(1'b0, 40'h00_1234_8000);
    st(OP_MAC, 1'b1, 1'b1, 16'h0);
    chk("wb write", 40'h0100_1235, {xwr.addr, xwr.data});
    chk("wb ptr", 40'h0102, 40'(ptr_data));
    st(OP_MSC, 1'b1, 1'b0, 16'h0); chk("wb direct", 40'({16'h1235, 1'b1, 1'b0}), {ptr_data, ptr_we, xwr.valid});
    for (int k = 4; k < 8; k++) begin
      st(dasr_op_t'(k), 1'b1, 1'b1, 16'h0); chk("no wb", 40'h0, {ptr_we, xwr.valid});
    end
    $display("test write-back finished");
    wacc(1'b0, 40'({$urandom, $urandom}));
    wacc(1'b1, 40'({$urandom, $urandom}));
    for (int i = 0; i < 30; i++) begin
      amt = (i == 0) ? -6'sd16 : (i == 1) ? 6'sd16 : (i == 2) ? 6'sd0 : 6'(int'($urandom_range(32)) - 16);
      x   = 16'($urandom);
      ar  = 1'($urandom);
      o   = (i % 3 != 2) ? acc_m[i % 3] : (amt < 0) ? {24'h0, x} : {{8{ar & x[15]}}, x, 16'h0};
      e   = exp_shift(o, ar, amt);
      @(posedge clk);
      sh_req <= '{1'b1, dasr_shsrc_t'(i % 3), ar, amt, x};
      step();
      chk("shift result", e, sh_res);
      chk("shift word", 40'((amt < 0) ? e[15:0] : e[31:16]), 40'(sh_word));
      chk("shift done", 40'h1, 40'(sh_done));
    end
    $display("test shift finished");
    end_sim();
  end
endmodule : dsp_accum_saturate_round_shift_tb_top
`default_nettype wire
